/* hw/adc_irq_pkg.sv */
// Register map, field layout and reset values of the converter interrupt block
package adc_irq_pkg;
  localparam int NUM_INPUTS = 12;
  localparam int NUM_COMPARATORS = 6;
  localparam int NUM_FILTERS = 2;
  localparam logic [11:0] OFS_INPUT_STATUS = 12'h000;
  localparam logic [11:0] OFS_INPUT_CLEAR = 12'h004;
  localparam logic [11:0] OFS_INPUT_ENABLE = 12'h008;
  localparam logic [11:0] OFS_INPUT_MODE = 12'h00C;
  localparam logic [11:0] OFS_MISC_STATUS = 12'h010;
  localparam logic [11:0] OFS_MISC_CLEAR = 12'h014;
  localparam logic [11:0] OFS_MISC_ENABLE = 12'h018;
  localparam logic [11:0] OFS_MISC_MODE = 12'h01C;
  localparam logic [11:0] OFS_VECTOR_BASE = 12'h020;
  localparam logic [11:0] OFS_CONTROL_ONE = 12'h024;
  localparam int SHIFT_LSB = 0;
  localparam int SHIFT_W = 3;
  localparam int MISC_CMP_LSB = 0;
  localparam int MISC_FLT_LSB = 8;
  localparam int MISC_REF_BIT = 12;
  localparam int MISC_FAULT_BIT = 13;
  localparam int MISC_SCAN_BIT = 14;
  localparam int MISC_AWAKE_BIT = 15;
  localparam int MISC_UPD_BIT = 16;
  localparam int MISC_W = 17;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_MODE_ALL = 32'hFFFF_FFFF;
endpackage

/* hw/adc_irq_vector.sv */
// Interrupt flags, enables, line drivers and vectored base read for the converter
`timescale 1ns/100ps
`default_nettype none

module adc_irq_vector
  import adc_irq_pkg::*;
#(
  parameter int N_IN = NUM_INPUTS,
  parameter int N_CMP = NUM_COMPARATORS,
  parameter int N_FLT = NUM_FILTERS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [N_IN-1:0] conversion_done_i,
  input wire logic [N_CMP-1:0] comparator_match_i,
  input wire logic [N_FLT-1:0] filter_done_i,
  input wire logic bandgap_ready_i,
  input wire logic reference_ready_i,
  input wire logic bandgap_fault_i,
  input wire logic reference_fault_i,
  input wire logic supply_brownout_i,
  input wire logic scan_complete_i,
  input wire logic converter_woken_i,
  input wire logic update_safe_i,
  output logic [N_IN-1:0] input_irq_o,
  output logic data_ready_irq_line_o,
  output logic comparator_irq_line_o,
  output logic filter_irq_line_o,
  output logic reference_ready_irq_line_o,
  output logic fault_irq_line_o,
  output logic scan_done_irq_line_o,
  output logic converter_awake_irq_line_o,
  output logic config_update_irq_line_o,
  output logic global_irq_o
);

  logic rst_meta;
  logic rst_sync_n;
  logic [N_IN-1:0] input_result_ready;
  logic [N_IN-1:0] input_global_irq_enable;
  logic [N_IN-1:0] input_mode;
  logic [MISC_W-1:0] misc_flag;
  logic [MISC_W-1:0] misc_enable;
  logic [MISC_W-1:0] misc_mode;
  logic [MISC_W-1:0] misc_event;
  logic [31:0] vector_base_reg;
  logic [SHIFT_W-1:0] vector_shift_amount;
  logic ref_both_q;
  logic [3:0] ready_index;
  logic [31:0] vector_read;
  logic [31:0] next_rdata;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [N_IN-1:0] input_active;
  logic [MISC_W-1:0] misc_active;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Zero wait state slave: access phase completes in its first cycle
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;

  // Gather miscellaneous events; reference ready needs both sources, on rising edge
  always_comb begin
    misc_event = '0;
    misc_event[MISC_CMP_LSB +: N_CMP] = comparator_match_i;
    misc_event[MISC_FLT_LSB +: N_FLT] = filter_done_i;
    misc_event[MISC_REF_BIT] = bandgap_ready_i && reference_ready_i && !ref_both_q;
    misc_event[MISC_FAULT_BIT] = bandgap_fault_i || reference_fault_i || supply_brownout_i;
    misc_event[MISC_SCAN_BIT] = scan_complete_i;
    misc_event[MISC_AWAKE_BIT] = converter_woken_i;
    misc_event[MISC_UPD_BIT] = update_safe_i;
  end

  // Edge memory so a steady ready level does not refire after software clears it
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_both_q <= 1'b0;
    end else begin
      ref_both_q <= bandgap_ready_i && reference_ready_i;
    end
  end

  // Sticky per-input ready flags; a new conversion wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_result_ready <= RST_ZERO[N_IN-1:0];
    end else begin
      if (wr_en && paddr_i == OFS_INPUT_CLEAR) begin
        input_result_ready <= (input_result_ready & ~pwdata_i[N_IN-1:0])
                              | conversion_done_i;
      end else begin
        input_result_ready <= input_result_ready | conversion_done_i;
      end
    end
  end

  // Sticky miscellaneous flags, set over clear
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      misc_flag <= RST_ZERO[MISC_W-1:0];
    end else begin
      if (wr_en && paddr_i == OFS_MISC_CLEAR) begin
        misc_flag <= (misc_flag & ~pwdata_i[MISC_W-1:0]) | misc_event;
      end else begin
        misc_flag <= misc_flag | misc_event;
      end
    end
  end

  // Enable and routing registers; mode bit set means the source also joins the global line
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_global_irq_enable <= RST_ZERO[N_IN-1:0];
      input_mode <= RST_MODE_ALL[N_IN-1:0];
      misc_enable <= RST_ZERO[MISC_W-1:0];
      misc_mode <= RST_MODE_ALL[MISC_W-1:0];
      vector_base_reg <= RST_ZERO;
      vector_shift_amount <= RST_ZERO[SHIFT_W-1:0];
    end else if (wr_en) begin
      case (paddr_i)
        OFS_INPUT_ENABLE: input_global_irq_enable <= pwdata_i[N_IN-1:0];
        OFS_INPUT_MODE: input_mode <= pwdata_i[N_IN-1:0];
        OFS_MISC_ENABLE: misc_enable <= pwdata_i[MISC_W-1:0];
        OFS_MISC_MODE: misc_mode <= pwdata_i[MISC_W-1:0];
        OFS_VECTOR_BASE: vector_base_reg <= pwdata_i;
        OFS_CONTROL_ONE: vector_shift_amount <= pwdata_i[SHIFT_LSB +: SHIFT_W];
        default: ;
      endcase
    end
  end

  // Lowest set index wins: scan downward so input zero is assigned last
  always_comb begin
    ready_index = 4'h0;
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (input_result_ready[i]) begin
        ready_index = 4'(i);
      end
    end
  end

  // Sum formed only when read; nothing ever writes it back to the base
  always_comb begin
    if (|input_result_ready) begin
      vector_read = vector_base_reg + (32'(ready_index) << vector_shift_amount);
    end else begin
      vector_read = vector_base_reg;
    end
  end

  // Read mux; clear registers read as zero
  always_comb begin
    addr_ok = 1'b1;
    next_rdata = RST_ZERO;
    case (paddr_i)
      OFS_INPUT_STATUS: next_rdata[N_IN-1:0] = input_result_ready;
      OFS_INPUT_CLEAR: next_rdata = RST_ZERO;
      OFS_INPUT_ENABLE: next_rdata[N_IN-1:0] = input_global_irq_enable;
      OFS_INPUT_MODE: next_rdata[N_IN-1:0] = input_mode;
      OFS_MISC_STATUS: next_rdata[MISC_W-1:0] = misc_flag;
      OFS_MISC_CLEAR: next_rdata = RST_ZERO;
      OFS_MISC_ENABLE: next_rdata[MISC_W-1:0] = misc_enable;
      OFS_MISC_MODE: next_rdata[MISC_W-1:0] = misc_mode;
      OFS_VECTOR_BASE: next_rdata = vector_read;
      OFS_CONTROL_ONE: next_rdata[SHIFT_LSB +: SHIFT_W] = vector_shift_amount;
      default: addr_ok = 1'b0;
    endcase
  end

  // Registered read data, taken in the setup cycle so it is valid in the access phase
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata_o <= RST_ZERO;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_o <= next_rdata;
      end
    end
  end

  // Active sources from the stored flags; the flopped lines follow them by one cycle
  assign input_active = input_result_ready & input_global_irq_enable;
  assign misc_active = misc_flag & misc_enable;

  // Individual and global lines, each from a flop
  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_irq_o <= '0;
      data_ready_irq_line_o <= 1'b0;
      comparator_irq_line_o <= 1'b0;
      filter_irq_line_o <= 1'b0;
      reference_ready_irq_line_o <= 1'b0;
      fault_irq_line_o <= 1'b0;
      scan_done_irq_line_o <= 1'b0;
      converter_awake_irq_line_o <= 1'b0;
      config_update_irq_line_o <= 1'b0;
      global_irq_o <= 1'b0;
    end else begin
      input_irq_o <= input_active;
      data_ready_irq_line_o <= |input_active;
      comparator_irq_line_o <= |misc_active[MISC_CMP_LSB +: N_CMP];
      filter_irq_line_o <= |misc_active[MISC_FLT_LSB +: N_FLT];
      reference_ready_irq_line_o <= misc_active[MISC_REF_BIT];
      fault_irq_line_o <= misc_active[MISC_FAULT_BIT];
      scan_done_irq_line_o <= misc_active[MISC_SCAN_BIT];
      converter_awake_irq_line_o <= misc_active[MISC_AWAKE_BIT];
      config_update_irq_line_o <= misc_active[MISC_UPD_BIT];
      global_irq_o <= |(input_active & input_mode) | |(misc_active & misc_mode);
    end
  end

  // Flag set by a conversion is seen the next cycle
  property p_input_set;
    @(posedge clk_i) disable iff (!rst_sync_n)
      conversion_done_i[0] |=> input_result_ready[0];
  endproperty
  a_input_set: assert property (p_input_set) else $error("input flag not set");

  property p_input_irq;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (input_result_ready[3] && input_global_irq_enable[3]) |=> input_irq_o[3];
  endproperty
  a_input_irq: assert property (p_input_irq) else $error("input line missing");

  property p_irq_drop;
    @(posedge clk_i) disable iff (!rst_sync_n)
      !input_result_ready[3] |=> !input_irq_o[3];
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("line high without flag");

  property p_fault;
    @(posedge clk_i) disable iff (!rst_sync_n)
      supply_brownout_i |=> misc_flag[MISC_FAULT_BIT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag not set");

  property p_ref_gate;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (!misc_flag[MISC_REF_BIT] && !(bandgap_ready_i && reference_ready_i))
        |=> !misc_flag[MISC_REF_BIT];
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("reference flag set early");

  property p_base_plain;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (input_result_ready == '0) |-> (vector_read == vector_base_reg);
  endproperty
  a_base_plain: assert property (p_base_plain) else $error("base read altered");

  property p_index0;
    @(posedge clk_i) disable iff (!rst_sync_n)
      input_result_ready[0] |-> (vector_read == vector_base_reg);
  endproperty
  a_index0: assert property (p_index0) else $error("input zero not highest");

  property p_base_kept;
    @(posedge clk_i) disable iff (!rst_sync_n)
      !(wr_en && paddr_i == OFS_VECTOR_BASE) |=> $stable(vector_base_reg);
  endproperty
  a_base_kept: assert property (p_base_kept) else $error("base changed by read");

  property p_global;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (misc_active[MISC_SCAN_BIT] && misc_mode[MISC_SCAN_BIT]) |=> global_irq_o;
  endproperty
  a_global: assert property (p_global) else $error("global line missing");

  property p_comparator_set;
    @(posedge clk_i) disable iff (!rst_sync_n)
      comparator_match_i[0] |=> misc_flag[MISC_CMP_LSB];
  endproperty
  a_comparator_set: assert property (p_comparator_set) else $error("match flag not set");

  property p_filter_set;
    @(posedge clk_i) disable iff (!rst_sync_n)
      filter_done_i[1] |=> misc_flag[MISC_FLT_LSB + 1];
  endproperty
  a_filter_set: assert property (p_filter_set) else $error("filter flag not set");

  property p_ref_set;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (bandgap_ready_i && reference_ready_i && !ref_both_q) |=> misc_flag[MISC_REF_BIT];
  endproperty
  a_ref_set: assert property (p_ref_set) else $error("reference flag not set");

  property p_scan_set;
    @(posedge clk_i) disable iff (!rst_sync_n)
      scan_complete_i |=> misc_flag[MISC_SCAN_BIT];
  endproperty
  a_scan_set: assert property (p_scan_set) else $error("scan flag not set");

  property p_awake_set;
    @(posedge clk_i) disable iff (!rst_sync_n)
      converter_woken_i |=> misc_flag[MISC_AWAKE_BIT];
  endproperty
  a_awake_set: assert property (p_awake_set) else $error("awake flag not set");

  property p_update_set;
    @(posedge clk_i) disable iff (!rst_sync_n)
      update_safe_i |=> misc_flag[MISC_UPD_BIT];
  endproperty
  a_update_set: assert property (p_update_set) else $error("update flag not set");

  property p_fault_line;
    @(posedge clk_i) disable iff (!rst_sync_n)
      misc_active[MISC_FAULT_BIT] |=> fault_irq_line_o;
  endproperty
  a_fault_line: assert property (p_fault_line) else $error("fault line missing");

  property p_ready_line;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (|(input_result_ready & input_global_irq_enable)) |=> data_ready_irq_line_o;
  endproperty
  a_ready_line: assert property (p_ready_line) else $error("ready line missing");

  property p_update_drop;
    @(posedge clk_i) disable iff (!rst_sync_n)
      !misc_flag[MISC_UPD_BIT] |=> !config_update_irq_line_o;
  endproperty
  a_update_drop: assert property (p_update_drop) else $error("update line stuck");

  property p_input_clear;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (wr_en && paddr_i == OFS_INPUT_CLEAR && pwdata_i[3] && !conversion_done_i[3])
        |=> !input_result_ready[3];
  endproperty
  a_input_clear: assert property (p_input_clear) else $error("input flag not cleared");

  // Global line must stay low when nothing enabled is routed to it
  property p_global_off;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (((input_active & input_mode) == '0) && ((misc_active & misc_mode) == '0))
        |=> !global_irq_o;
  endproperty
  a_global_off: assert property (p_global_off) else $error("global line spurious");

  property p_vector_two;
    @(posedge clk_i) disable iff (!rst_sync_n)
      (input_result_ready[1:0] == 2'b00 && input_result_ready[2])
        |-> (vector_read == vector_base_reg + (32'h0000_0002 << vector_shift_amount));
  endproperty
  a_vector_two: assert property (p_vector_two) else $error("vector sum wrong");

endmodule // adc_irq_vector
`default_nettype wire

/* test/irq_sink_model.sv */
// Interrupt controller stand-in that counts global interrupt requests
`timescale 1ns/100ps
`default_nettype none
module irq_sink_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic global_irq_i,
  output var int rises_o
);
  logic seen;
  // One entry into the shared service routine per rising request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen <= 1'b0;
      rises_o <= 0;
    end else begin
      seen <= global_irq_i;
      if (global_irq_i && !seen) rises_o <= rises_o + 1;
    end
  end
endmodule // irq_sink_model
`default_nettype wire

/* test/tb_adc_irq_vector.sv */
// Self-checking bench for the converter interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_adc_irq_vector;
  import adc_irq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, glob;
  logic [11:0] conv = 12'h000, in_irq;
  logic [5:0] cmp = 6'h00;
  logic [1:0] flt = 2'h0;
  logic bg_rdy = 0, ref_rdy = 0, bg_flt = 0, ref_flt = 0, brown = 0, scan = 0, woken = 0, upd = 0;
  logic [7:0] lines;
  int err_total = 0, samples_checked = 0, global_rises;
  // Rows: event code, misc status bit it sets, individual line it raises
  int row_ev[15] = '{0, 1, 2, 3, 4, 5, 8, 9, 12, 13, 17, 18, 14, 15, 16};
  int row_bit[15] = '{0, 1, 2, 3, 4, 5, 8, 9, 12, 13, 13, 13, 14, 15, 16};
  logic [7:0] row_line[15] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h20, 8'h20,
                               8'h10, 8'h08, 8'h08, 8'h08, 8'h04, 8'h02, 8'h01};
  always #25 clk_i = ~clk_i;
  adc_irq_vector i_adc_irq_vector (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .conversion_done_i(conv),
    .comparator_match_i(cmp), .filter_done_i(flt), .bandgap_ready_i(bg_rdy),
    .reference_ready_i(ref_rdy), .bandgap_fault_i(bg_flt), .reference_fault_i(ref_flt),
    .supply_brownout_i(brown), .scan_complete_i(scan), .converter_woken_i(woken),
    .update_safe_i(upd), .input_irq_o(in_irq), .data_ready_irq_line_o(lines[7]),
    .comparator_irq_line_o(lines[6]), .filter_irq_line_o(lines[5]),
    .reference_ready_irq_line_o(lines[4]), .fault_irq_line_o(lines[3]),
    .scan_done_irq_line_o(lines[2]), .converter_awake_irq_line_o(lines[1]),
    .config_update_irq_line_o(lines[0]), .global_irq_o(glob));
  irq_sink_model i_irq_sink_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .global_irq_i(glob),
    .rises_o(global_rises));
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wrap_up();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Setup cycle, then hold the access phase until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) err_total++;
  endtask
  task drive(input int c, input logic v);
    if (c >= 20) conv[c-20] <= v;
    else if (c < 6) cmp[c] <= v;
    else if (c < 10) flt[c-8] <= v;
    else if (c == 12) begin
      bg_rdy <= v;
      ref_rdy <= v;
    end else if (c == 13) bg_flt <= v;
    else if (c == 14) scan <= v;
    else if (c == 15) woken <= v;
    else if (c == 16) upd <= v;
    else if (c == 17) ref_flt <= v;
    else brown <= v;
  endtask
  // One-cycle event, then wait until its line has had time to follow
  task ev(input int c);
    @(posedge clk_i);
    drive(c, 1'b1);
    @(posedge clk_i);
    drive(c, 1'b0);
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task vchk(input logic [31:0] sh, input logic [31:0] exp);
    apb(1'b1, OFS_CONTROL_ONE, sh);
    apb(1'b0, OFS_VECTOR_BASE, 32'h0000_0000);
    chk("vector_read", rd, exp);
  endtask
  // Watchdog sized well beyond the whole sequence
  initial begin
    #(50 * 20000);
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("outputs_reset", {11'h000, in_irq, lines, glob}, 32'h0000_0000);
    chk("prdata_reset", prdata, 32'h0000_0000);
    chk("apb_flags_reset", {30'h0, pready, pslverr}, 32'h0000_0000);
    apb(1'b0, OFS_MISC_MODE, 32'h0000_0000);
    chk("misc_mode_reset", {15'h0000, rd[16:0]}, 32'h0001_FFFF);
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
    chk("unmapped_err", {31'h0, er}, 32'h0000_0001);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("unmapped_read", rd, 32'h0000_0000);
    apb(1'b1, OFS_MISC_ENABLE, 32'h0001_FFFF);
    for (int i = 0; i < 15; i++) begin
      ev(row_ev[i]);
      chk("misc_lines", {24'h0, lines}, {24'h0, row_line[i]});
      chk("global_on", {31'h0, glob}, 32'h0000_0001);
      apb(1'b0, OFS_MISC_STATUS, 32'h0000_0000);
      chk("misc_status", rd, 32'h0000_0001 << row_bit[i]);
      apb(1'b1, OFS_MISC_CLEAR, 32'h0000_0001 << row_bit[i]);
      repeat (2) @(posedge clk_i);
      #1;
      chk("lines_cleared", {23'h0, lines, glob}, 32'h0000_0000);
    end
    chk("global_entries", 32'(global_rises), 32'd15);
    // Band gap ready alone must not set the reference flag
    @(posedge clk_i);
    bg_rdy <= 1'b1;
    repeat (3) @(posedge clk_i);
    bg_rdy <= 1'b0;
    apb(1'b0, OFS_MISC_STATUS, 32'h0000_0000);
    chk("ref_half_ready", rd, 32'h0000_0000);
    // Masked source keeps its flag; mode split between individual and global
    apb(1'b1, OFS_MISC_ENABLE, 32'h0000_0000);
    ev(14);
    chk("scan_masked", {31'h0, lines[2]}, 32'h0000_0000);
    apb(1'b1, OFS_MISC_MODE, 32'hFFFF_BFFF);
    apb(1'b1, OFS_MISC_ENABLE, 32'h0000_4000);
    repeat (3) @(posedge clk_i);
    #1;
    chk("scan_individual", {30'h0, lines[2], glob}, 32'h0000_0002);
    apb(1'b1, OFS_MISC_MODE, 32'hFFFF_FFFF);
    repeat (3) @(posedge clk_i);
    #1;
    chk("scan_global", {31'h0, glob}, 32'h0000_0001);
    // Per-input enables and the vectored base read
    ev(23);
    chk("input_masked", {20'h0, in_irq}, 32'h0000_0000);
    apb(1'b1, OFS_INPUT_ENABLE, 32'h0000_0008);
    repeat (3) @(posedge clk_i);
    #1;
    chk("input_irq", {19'h0, lines[7], in_irq}, 32'h0000_1008);
    apb(1'b1, OFS_VECTOR_BASE, 32'h0000_1234);
    ev(25);
    ev(22);
    vchk(32'h0000_0002, 32'h0000_123C);
    vchk(32'h0000_0002, 32'h0000_123C);
    vchk(32'h0000_0007, 32'h0000_1334);
    apb(1'b1, OFS_INPUT_CLEAR, 32'h0000_000C);
    repeat (2) @(posedge clk_i);
    #1;
    chk("input_cleared", {20'h0, in_irq}, 32'h0000_0000);
    vchk(32'h0000_0007, 32'h0000_14B4);
    apb(1'b1, OFS_INPUT_CLEAR, 32'h0000_0020);
    ev(31);
    vchk(32'h0000_0003, 32'h0000_128C);
    apb(1'b1, OFS_INPUT_CLEAR, 32'h0000_0FFF);
    vchk(32'h0000_0003, 32'h0000_1234);
    // Conversion landing on the clearing edge keeps its flag
    ev(20);
    fork
      apb(1'b1, OFS_INPUT_CLEAR, 32'h0000_0001);
      begin
        repeat (2) @(posedge clk_i);
        conv[0] <= 1'b1;
        @(posedge clk_i);
        conv[0] <= 1'b0;
      end
    join
    apb(1'b0, OFS_INPUT_STATUS, 32'h0000_0000);
    chk("set_over_clear", rd, 32'h0000_0001);
    // Input routed only to its own line, then joined to the global line
    apb(1'b1, OFS_MISC_CLEAR, 32'h0000_4000);
    apb(1'b1, OFS_INPUT_MODE, 32'h0000_0000);
    ev(23);
    chk("input_individual", {30'h0, in_irq[3], glob}, 32'h0000_0002);
    apb(1'b1, OFS_INPUT_MODE, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    #1;
    chk("input_global", {31'h0, glob}, 32'h0000_0001);
    wrap_up();
  end
endmodule // tb_adc_irq_vector
`default_nettype wire
